// ===== inc/cscalu_pkg.sv
// constants and types of the cpu status, core control and integer arithmetic block
package cscalu_pkg;
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] CORE_CTL_OFS = 4'h4;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CORE_CTL_RST = 16'h0020;
  localparam logic [15:0] CC_WR_MASK = 16'h10f7;
  localparam logic [2:0] PRIO_USER_OFF = 3'h7;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  localparam int ST_SPILL_A = 15;
  localparam int ST_SPILL_B = 14;
  localparam int ST_CLIP_A = 13;
  localparam int ST_CLIP_B = 12;
  localparam int ST_ANY_SPILL = 11;
  localparam int ST_ANY_CLIP = 10;
  localparam int ST_DO_ACT = 9;
  localparam int ST_HALF_C = 8;
  localparam int ST_PRIO_HI = 7;
  localparam int ST_PRIO_LO = 5;
  localparam int ST_REP_ACT = 4;
  localparam int ST_NEG = 3;
  localparam int ST_WRAP = 2;
  localparam int ST_ZERO = 1;
  localparam int ST_CARRY = 0;
  localparam int CC_MUL_US = 12;
  localparam int CC_EARLY = 11;
  localparam int CC_DEPTH_HI = 10;
  localparam int CC_DEPTH_LO = 8;
  localparam int CC_PRIO_MSB = 3;
  localparam int CC_INT = 0;
  localparam int FM_HALF = 4;
  localparam int FM_NEG = 3;
  localparam int FM_WRAP = 2;
  localparam int FM_ZERO = 1;
  localparam int FM_CARRY = 0;
  typedef enum logic [3:0] {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
    OP_SLL, OP_LSR, OP_ASR} cscalu_op_t;
  typedef enum logic [2:0] {MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_UU8,
    MUL_DSP} cscalu_mul_t;
  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_FIX} cscalu_dst_t;
  typedef struct packed {logic valid; cscalu_op_t op; logic byte_op; logic [15:0] a;
    logic [15:0] b; logic [4:0] affect;} cscalu_alu_req_t;
  typedef struct packed {logic valid; logic [15:0] result;} cscalu_alu_rsp_t;
  typedef struct packed {logic valid; cscalu_mul_t mode; logic [15:0] a;
    logic [15:0] b;} cscalu_mul_req_t;
  typedef struct packed {logic valid; logic [31:0] product;} cscalu_mul_rsp_t;
  typedef struct packed {logic start; logic sgn; logic wide; logic [31:0] dividend;
    logic [15:0] divisor;} cscalu_div_req_t;
  typedef struct packed {logic busy; logic done; logic [15:0] quotient_work_reg;
    logic [15:0] remainder_work_reg;} cscalu_div_rsp_t;
  typedef struct packed {logic upd_a; logic spill_a; logic clip_a; logic upd_b;
    logic spill_b; logic clip_b;} cscalu_acc_evt_t;
  typedef struct packed {logic do_loop_active; logic repeat_loop_active;
    logic [2:0] do_nest_depth; logic nesting_disable; logic prio_load;
    logic [3:0] prio_value;} cscalu_core_in_t;
  typedef struct packed {
    logic [15:0] sr;
    logic [15:0] cc;
    logic ack;
    logic [31:0] rdata;
    logic early_exit;
    logic user_irq_off;
    cscalu_alu_rsp_t alu;
    cscalu_mul_rsp_t mul;
    cscalu_dst_t dst;
    logic [4:0] cnt;
    logic [16:0] rem;
    logic [15:0] quo;
    logic [15:0] dvs;
    logic neg_q;
    logic neg_r;
    cscalu_div_rsp_t div;
  } cscalu_state_t;
endpackage

// ===== rtl/cscalu_core.sv
// cpu status word, core control word, integer alu flags, multiplier and divider
// Overview of operation
// - status bits 15/14 flag accumulator A/B guard spill; bit 11 is their OR
// - bits 13/12 stick high once accumulator A/B clips
// - software may only clear sticky clip flags, never set them
// - bit 10 is OR of clip flags; clearing it clears both
// - bit 9 shows a DO loop running, bit 4 a REPEAT loop
// - bit 8 is carry out of low nibble (byte) or low byte (word)
// - bits 7-5 plus priority msb form level; user irqs off at 7 or msb
// - priority bits 7-5 ignore software writes while nesting is disabled
// - bit 3 set on negative result, cleared otherwise
// - bit 2 set on signed two's complement overflow, cleared otherwise
// - zero flag cleared by a non-zero result of a zero-affecting op or by a software write of zero
// - bit 0 is carry out of result msb, active-low borrow on subtract
// - control bit 12 selects unsigned dsp multiply; bits 15-13 read zero
// - writing one to control bit 11 ends the DO loop; reads zero
// - control bits 10-8 report active DO loop count 0..7
// - control bits 7/6/5 enable clipping A/B/stores; bit 5 resets to one
// - control bit 4 selects 9.31 clipping when one, 1.31 when zero
// - control bit 2 makes program space visible in data window
// - control bit 1 biased rounding, bit 0 integer dsp multiply
// - alu is 16 bits wide with byte and word add, sub, shift, logic
// - multiplier offers signed, unsigned, mixed, literal and byte modes
// - divider does 32/16 and 16/16 at one cycle per divisor bit
`timescale 1ns/1ps
module cscalu_core
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire cscalu_pkg::cscalu_alu_req_t alu_req,
  input wire cscalu_pkg::cscalu_mul_req_t mul_req,
  input wire cscalu_pkg::cscalu_div_req_t div_req,
  input wire cscalu_pkg::cscalu_acc_evt_t acc_evt,
  input wire cscalu_pkg::cscalu_core_in_t core_in,
  output logic [15:0] cpu_status_word,
  output logic [15:0] core_control_word,
  output logic user_irq_off,
  output logic do_loop_early_exit,
  output cscalu_pkg::cscalu_alu_rsp_t alu_rsp,
  output cscalu_pkg::cscalu_mul_rsp_t mul_rsp,
  output cscalu_pkg::cscalu_div_rsp_t div_rsp
);
  import cscalu_pkg::*;

  cscalu_state_t st_r;
  cscalu_state_t st_nxt;
  logic acc;
  logic wr_sr;
  logic wr_cc;
  logic [15:0] wd;
  logic [15:0] wm;
  logic [15:0] bx;
  logic cin;
  logic sub;
  logic [16:0] sum_w;
  logic [8:0] sum_b;
  logic [4:0] nib;
  logic [15:0] res;
  logic [4:0] fl;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] prod;
  logic [31:0] dmag;
  logic [16:0] trial;
  logic clr_a;
  logic clr_b;

  // a request is served once; the answer is the registered ack one cycle later
  assign acc = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign wr_sr = acc && wb_we_i && (wb_adr_i == STATUS_OFS);
  assign wr_cc = acc && wb_we_i && (wb_adr_i == CORE_CTL_OFS);
  assign wd = wb_dat_i[15:0];
  assign wm = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb
  begin
    sub = (alu_req.op == OP_SUB) || (alu_req.op == OP_SUBB);
    bx = sub ? ~alu_req.b : alu_req.b;
    case (alu_req.op)
      OP_ADDC, OP_SUBB: cin = st_r.sr[ST_CARRY];
      OP_SUB: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum_w = {1'b0, alu_req.a} + {1'b0, bx} + {16'h0000, cin};
    sum_b = {1'b0, alu_req.a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    nib = {1'b0, alu_req.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    msb_a = alu_req.byte_op ? alu_req.a[7] : alu_req.a[15];
    msb_b = alu_req.byte_op ? bx[7] : bx[15];
    // fl holds half carry, negative, wrap, zero, carry
    fl = 5'h00;
    res = 16'h0000;
    case (alu_req.op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB:
      begin
        res = alu_req.byte_op ? {8'h00, sum_b[7:0]} : sum_w[15:0];
        fl[FM_CARRY] = alu_req.byte_op ? sum_b[8] : sum_w[16];
        fl[FM_HALF] = alu_req.byte_op ? nib[4] : sum_b[8];
      end
      OP_AND: res = alu_req.a & alu_req.b;
      OP_IOR: res = alu_req.a | alu_req.b;
      OP_XOR: res = alu_req.a ^ alu_req.b;
      OP_SLL:
      begin
        res = {alu_req.a[14:0], 1'b0};
        fl[FM_CARRY] = msb_a;
      end
      OP_LSR:
      begin
        res = alu_req.byte_op ? {9'h000, alu_req.a[7:1]} : {1'b0, alu_req.a[15:1]};
        fl[FM_CARRY] = alu_req.a[0];
      end
      OP_ASR:
      begin
        res = alu_req.byte_op ? {8'h00, msb_a, alu_req.a[7:1]} : {msb_a, alu_req.a[15:1]};
        fl[FM_CARRY] = alu_req.a[0];
      end
      default: res = 16'h0000;
    endcase
    if (alu_req.byte_op)
      res[15:8] = 8'h00;
    msb_r = alu_req.byte_op ? res[7] : res[15];
    fl[FM_NEG] = msb_r;
    fl[FM_WRAP] = (alu_req.op <= OP_SUBB) && (msb_a == msb_b) && (msb_r != msb_a);
    fl[FM_ZERO] = (res == 16'h0000);
  end

  always_comb
  begin
    // operand extension into the 17th bit
    ma = {mul_req.a[15], mul_req.a};
    mb = {mul_req.b[15], mul_req.b};
    case (mul_req.mode)
      MUL_UU: begin ma[16] = 1'b0; mb[16] = 1'b0; end
      MUL_SU: mb[16] = 1'b0;
      MUL_US: ma[16] = 1'b0;
      MUL_SLIT: mb = {12'h000, mul_req.b[4:0]};
      MUL_ULIT: begin ma[16] = 1'b0; mb = {12'h000, mul_req.b[4:0]}; end
      MUL_UU8: begin ma = {9'h000, mul_req.a[7:0]}; mb = {9'h000, mul_req.b[7:0]}; end
      MUL_DSP:
      if (st_r.cc[CC_MUL_US])
      begin
        ma[16] = 1'b0;
        mb[16] = 1'b0;
      end
      default: ma = {mul_req.a[15], mul_req.a};
    endcase
    prod = $signed(ma) * $signed(mb);
  end

  always_comb
  begin
    // magnitude of a sign- or zero-extended dividend
    dmag = div_req.wide ? div_req.dividend
      : {{16{div_req.sgn & div_req.dividend[15]}}, div_req.dividend[15:0]};
    if (div_req.sgn && dmag[31])
      dmag = 32'h0000_0000 - dmag;
    trial = {st_r.rem[15:0], st_r.quo[15]};
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = acc;
    st_nxt.rdata = 32'h0000_0000;
    if (acc && !wb_we_i && (wb_adr_i == STATUS_OFS))
      st_nxt.rdata = {16'h0000, st_r.sr};
    if (acc && !wb_we_i && (wb_adr_i == CORE_CTL_OFS))
      st_nxt.rdata = {16'h0000, st_r.cc};
    // a written zero only clears; selected lanes only
    clr_a = wr_sr && wm[ST_CLIP_A] && !wd[ST_CLIP_A];
    clr_b = wr_sr && wm[ST_CLIP_B] && !wd[ST_CLIP_B];
    // clearing the combined flag clears both
    if (wr_sr && wm[ST_ANY_CLIP] && !wd[ST_ANY_CLIP])
    begin
      clr_a = 1'b1;
      clr_b = 1'b1;
    end
    // a clip event wins over a clear in the same cycle
    st_nxt.sr[ST_CLIP_A] = (st_r.sr[ST_CLIP_A] && !clr_a) || (acc_evt.upd_a && acc_evt.clip_a);
    st_nxt.sr[ST_CLIP_B] = (st_r.sr[ST_CLIP_B] && !clr_b) || (acc_evt.upd_b && acc_evt.clip_b);
    // guard spill follows the latest accumulator pass
    if (acc_evt.upd_a)
      st_nxt.sr[ST_SPILL_A] = acc_evt.spill_a;
    if (acc_evt.upd_b)
      st_nxt.sr[ST_SPILL_B] = acc_evt.spill_b;
    // software writes to the plain alu flags; a same-cycle alu result overrides below
    if (wr_sr)
    begin
      st_nxt.sr[ST_HALF_C] = wm[ST_HALF_C] ? wd[ST_HALF_C] : st_r.sr[ST_HALF_C];
      st_nxt.sr[3:0] = (wd[3:0] & wm[3:0]) | (st_r.sr[3:0] & ~wm[3:0]);
      // priority bits locked while nesting is disabled
      if (!core_in.nesting_disable && wm[ST_PRIO_HI])
      begin
        st_nxt.sr[ST_PRIO_HI:ST_PRIO_LO] = wd[ST_PRIO_HI:ST_PRIO_LO];
      end
    end
    // only flags named in the affect mask move
    if (alu_req.valid)
    begin
      if (alu_req.affect[FM_HALF]) st_nxt.sr[ST_HALF_C] = fl[FM_HALF];
      if (alu_req.affect[FM_NEG]) st_nxt.sr[ST_NEG] = fl[FM_NEG];
      if (alu_req.affect[FM_WRAP]) st_nxt.sr[ST_WRAP] = fl[FM_WRAP];
      if (alu_req.affect[FM_ZERO]) st_nxt.sr[ST_ZERO] = fl[FM_ZERO];
      if (alu_req.affect[FM_CARRY]) st_nxt.sr[ST_CARRY] = fl[FM_CARRY];
    end
    st_nxt.alu.valid = alu_req.valid;
    if (alu_req.valid)
      st_nxt.alu.result = res;
    // core control: software half
    if (wr_cc)
    begin
      st_nxt.cc = (st_r.cc & ~(CC_WR_MASK & wm)) | (wd & CC_WR_MASK & wm);
      if (wm[CC_PRIO_MSB] && !wd[CC_PRIO_MSB])
        st_nxt.cc[CC_PRIO_MSB] = 1'b0;
    end
    // early exit is a one-cycle pulse, never stored
    st_nxt.early_exit = wr_cc && wm[CC_EARLY] && wd[CC_EARLY];
    // unimplemented control bits and write-only exit bit read zero
    st_nxt.cc[15:CC_EARLY] = {4'h0, 1'b0} | {3'h0, st_nxt.cc[CC_MUL_US], 1'b0};
    // nesting depth from the loop sequencer
    st_nxt.cc[CC_DEPTH_HI:CC_DEPTH_LO] = core_in.do_nest_depth;
    // interrupt controller priority load beats a software write
    if (core_in.prio_load)
    begin
      st_nxt.sr[ST_PRIO_HI:ST_PRIO_LO] = core_in.prio_value[2:0];
      st_nxt.cc[CC_PRIO_MSB] = core_in.prio_value[3];
    end
    st_nxt.sr[ST_DO_ACT] = core_in.do_loop_active;
    st_nxt.sr[ST_REP_ACT] = core_in.repeat_loop_active;
    st_nxt.sr[ST_ANY_SPILL] = st_nxt.sr[ST_SPILL_A] | st_nxt.sr[ST_SPILL_B];
    st_nxt.sr[ST_ANY_CLIP] = st_nxt.sr[ST_CLIP_A] | st_nxt.sr[ST_CLIP_B];
    // user interrupts off at level 7 or with the msb set
    st_nxt.user_irq_off = st_nxt.cc[CC_PRIO_MSB]
      || (st_nxt.sr[ST_PRIO_HI:ST_PRIO_LO] == PRIO_USER_OFF);
    // one-cycle multiplier; dsp fractional doubles the product
    st_nxt.mul.valid = mul_req.valid;
    if (mul_req.valid)
    begin
      st_nxt.mul.product = prod[31:0];
      if ((mul_req.mode == MUL_DSP) && !st_r.cc[CC_INT])
        st_nxt.mul.product = {prod[30:0], 1'b0};
    end
    // restoring divider, one divisor bit per cycle
    st_nxt.div.done = 1'b0;
    case (st_r.dst)
      DIV_IDLE:
      if (div_req.start)
      begin
        st_nxt.rem = {1'b0, dmag[31:16]};
        st_nxt.quo = dmag[15:0];
        st_nxt.dvs = (div_req.sgn && div_req.divisor[15]) ? 16'h0000 - div_req.divisor
          : div_req.divisor;
        st_nxt.neg_r = div_req.sgn && (div_req.wide ? div_req.dividend[31]
          : div_req.dividend[15]);
        st_nxt.neg_q = st_nxt.neg_r ^ (div_req.sgn && div_req.divisor[15]);
        st_nxt.cnt = DIV_STEPS;
        st_nxt.dst = DIV_RUN;
        st_nxt.div.busy = 1'b1;
      end
      DIV_RUN:
      begin
        if (trial >= {1'b0, st_r.dvs})
        begin
          st_nxt.rem = trial - {1'b0, st_r.dvs};
          st_nxt.quo = {st_r.quo[14:0], 1'b1};
        end
        else
        begin
          st_nxt.rem = trial;
          st_nxt.quo = {st_r.quo[14:0], 1'b0};
        end
        st_nxt.cnt = st_r.cnt - 5'h01;
        if (st_r.cnt == 5'h01)
          st_nxt.dst = DIV_FIX;
      end
      DIV_FIX:
      begin
        st_nxt.div.quotient_work_reg = st_r.neg_q ? 16'h0000 - st_r.quo : st_r.quo;
        st_nxt.div.remainder_work_reg = st_r.neg_r ? 16'h0000 - st_r.rem[15:0]
          : st_r.rem[15:0];
        st_nxt.div.done = 1'b1;
        st_nxt.div.busy = 1'b0;
        st_nxt.dst = DIV_IDLE;
      end
      default: st_nxt.dst = DIV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.cc <= CORE_CTL_RST;
      st_r.sr <= STATUS_RST;
      st_r.dst <= DIV_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign cpu_status_word = st_r.sr;
  assign core_control_word = st_r.cc;
  assign user_irq_off = st_r.user_irq_off;
  assign do_loop_early_exit = st_r.early_exit;
  assign alu_rsp = st_r.alu;
  assign mul_rsp = st_r.mul;
  assign div_rsp = st_r.div;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_clip_a;
    acc_evt.upd_a && acc_evt.clip_a;
  endsequence
  sequence s_div_run;
    st_r.div.busy [*8];
  endsequence

  property p_spill;
    acc_evt.upd_a && acc_evt.spill_a |=> st_r.sr[ST_SPILL_A] && st_r.sr[ST_ANY_SPILL];
  endproperty
  a_spill: assert property (p_spill) else $error("spill flag missed");
  property p_sticky;
    s_clip_a |=> st_r.sr[ST_CLIP_A] ##1 (st_r.sr[ST_CLIP_A] || $past(clr_a));
  endproperty
  a_sticky: assert property (p_sticky) else $error("clip flag dropped");
  property p_noset;
    !st_r.sr[ST_CLIP_B] && !(acc_evt.upd_b && acc_evt.clip_b) |=> !st_r.sr[ST_CLIP_B];
  endproperty
  a_noset: assert property (p_noset) else $error("clip flag set by write");
  property p_anyclr;
    wr_sr && wm[ST_ANY_CLIP] && !wd[ST_ANY_CLIP] && !acc_evt.upd_a && !acc_evt.upd_b
      |=> !st_r.sr[ST_CLIP_A] && !st_r.sr[ST_CLIP_B] && !st_r.sr[ST_ANY_CLIP];
  endproperty
  a_anyclr: assert property (p_anyclr) else $error("combined clear failed");
  property p_irqoff;
    st_r.user_irq_off == (st_r.cc[CC_PRIO_MSB] || (st_r.sr[7:5] == PRIO_USER_OFF));
  endproperty
  a_irqoff: assert property (p_irqoff) else $error("irq disable wrong");
  property p_lock;
    wr_sr && core_in.nesting_disable && !core_in.prio_load |=> $stable(st_r.sr[7:5]);
  endproperty
  a_lock: assert property (p_lock) else $error("priority written while locked");
  property p_zero;
    alu_req.valid && alu_req.affect[FM_ZERO] && (res != 16'h0000) |=> !st_r.sr[ST_ZERO];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not cleared");
  property p_exit;
    wr_cc && wm[CC_EARLY] && wd[CC_EARLY] |=> do_loop_early_exit && !st_r.cc[CC_EARLY]
      ##1 !do_loop_early_exit;
  endproperty
  a_exit: assert property (p_exit) else $error("early exit pulse wrong");
  property p_div;
    st_r.dst == DIV_IDLE && div_req.start |=> s_div_run ##10 st_r.div.done;
  endproperty
  a_div: assert property (p_div) else $error("divide timing wrong");
  property p_hold;
    alu_req.valid && alu_req.affect == 5'h00 && !wr_sr |=> $stable(st_r.sr[3:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("unaffected flag moved");
endmodule

// ===== verification/cscalu_cpu_model.sv
// behavioural model of the instruction pipeline that issues alu, multiply and divide work
`timescale 1ns/1ps
module cscalu_cpu_model
(
  input wire logic clk_sys,
  output cscalu_pkg::cscalu_alu_req_t alu_req,
  output cscalu_pkg::cscalu_mul_req_t mul_req,
  output cscalu_pkg::cscalu_div_req_t div_req,
  input wire cscalu_pkg::cscalu_alu_rsp_t alu_rsp,
  input wire cscalu_pkg::cscalu_mul_rsp_t mul_rsp,
  input wire cscalu_pkg::cscalu_div_rsp_t div_rsp
);
  import cscalu_pkg::*;
  initial
  begin
    alu_req = '0;
    mul_req = '0;
    div_req = '0;
  end
  // one operand is scrambled once valid drops, so a late sample gives a wrong answer
  task automatic alu_run(input cscalu_op_t op, input logic byt, input logic [15:0] a, b,
    input logic [4:0] aff, output logic [15:0] res);
    int n;
    @(posedge clk_sys);
    alu_req <= '{1'b1, op, byt, a, b, aff};
    @(posedge clk_sys);
    alu_req.valid <= 1'b0;
    alu_req.a <= ~a;
    for (n = 0; n < 20 && alu_rsp.valid !== 1'b1; n++) @(posedge clk_sys);
    res = alu_rsp.result;
  endtask
  task automatic mul_run(input cscalu_mul_t md, input logic [15:0] a, b, output logic [31:0] p);
    int n;
    @(posedge clk_sys);
    mul_req <= '{1'b1, md, a, b};
    @(posedge clk_sys);
    mul_req.valid <= 1'b0;
    mul_req.b <= ~b;
    for (n = 0; n < 20 && mul_rsp.valid !== 1'b1; n++) @(posedge clk_sys);
    p = mul_rsp.product;
  endtask
  // poke issues a second start with another divisor while busy; it must be ignored
  task automatic div_run(input logic sgn, wide, poke, input logic [31:0] dvd,
    input logic [15:0] dvs, output logic [15:0] q, r, output int nb);
    int n;
    nb = 0;
    @(posedge clk_sys);
    div_req <= '{1'b1, sgn, wide, dvd, dvs};
    @(posedge clk_sys);
    div_req.start <= 1'b0;
    for (n = 0; n < 100 && div_rsp.done !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      if (div_rsp.busy === 1'b1)
        nb++;
      div_req.start <= poke && n == 3;
      div_req.divisor <= poke ? 16'h0001 : dvs;
    end
    q = div_rsp.quotient_work_reg;
    r = div_rsp.remainder_work_reg;
  endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the status, core control and arithmetic block
`timescale 1ns/1ps
module tb_top;
  import cscalu_pkg::*;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, user_irq_off, do_loop_early_exit;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] cpu_status_word, core_control_word;
  cscalu_alu_req_t alu_req;
  cscalu_mul_req_t mul_req;
  cscalu_div_req_t div_req;
  cscalu_alu_rsp_t alu_rsp;
  cscalu_mul_rsp_t mul_rsp;
  cscalu_div_rsp_t div_rsp;
  cscalu_acc_evt_t acc_evt;
  cscalu_core_in_t core_in;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_exit = 0;
  cscalu_core cscalu_core_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .alu_req(alu_req),
    .mul_req(mul_req), .div_req(div_req), .acc_evt(acc_evt), .core_in(core_in),
    .cpu_status_word(cpu_status_word), .core_control_word(core_control_word),
    .user_irq_off(user_irq_off), .do_loop_early_exit(do_loop_early_exit),
    .alu_rsp(alu_rsp), .mul_rsp(mul_rsp), .div_rsp(div_rsp));
  cscalu_cpu_model cscalu_cpu_model_i (.clk_sys(clk_sys), .alu_req(alu_req),
    .mul_req(mul_req), .div_req(div_req), .alu_rsp(alu_rsp), .mul_rsp(mul_rsp),
    .div_rsp(div_rsp));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (do_loop_early_exit === 1'b1)
      n_exit <= n_exit + 1;
  task automatic check(input logic [31:0] seen, ex);
    n_tests++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, ex);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
    output logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'h3;
    @(posedge clk_sys);
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_sys);
    d = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 20)
      n_mismatch++;
  endtask
  task automatic evt(input logic [5:0] e);
    @(posedge clk_sys);
    acc_evt <= cscalu_acc_evt_t'(e);
    @(posedge clk_sys);
    acc_evt <= '0;
    @(posedge clk_sys);
  endtask
  task automatic alu_chk(input cscalu_op_t op, input logic byt, input logic [15:0] a, b,
    input logic [4:0] aff, input logic [15:0] er, input logic [4:0] ef);
    logic [15:0] res;
    cscalu_cpu_model_i.alu_run(op, byt, a, b, aff, res);
    check(res, er);
    check({cpu_status_word[ST_HALF_C], cpu_status_word[3:0]}, ef);
  endtask
  task automatic mul_chk(input cscalu_mul_t md, input logic [15:0] a, b, input logic [31:0] ex);
    logic [31:0] p;
    cscalu_cpu_model_i.mul_run(md, a, b, p);
    check(p, ex);
  endtask
  task automatic div_chk(input logic sgn, wide, poke, input logic [31:0] dvd,
    input logic [15:0] dvs, input logic [31:0] ex);
    logic [15:0] q, r;
    int nb;
    cscalu_cpu_model_i.div_run(sgn, wide, poke, dvd, dvs, q, r, nb);
    check({q, r}, ex);
    check(nb, 32'h11);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a few hundred cycles are expected; this leaves a wide margin for a hang
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    acc_evt = '0;
    core_in = '0;
    repeat (10) @(posedge clk_sys);
    check(core_control_word, 32'h0020);
    rst <= 1'b0;
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b0, CORE_CTL_OFS, 32'h0, rd);
    check(rd, 32'h0020);
    core_in.do_nest_depth <= 3'h5;
    wb(1'b1, CORE_CTL_OFS, 32'hffff, rd);
    wb(1'b0, CORE_CTL_OFS, 32'h0, rd);
    check(rd, 32'h15f7);
    check(n_exit, 32'h1);
    mul_chk(MUL_DSP, 16'hffff, 16'h0002, 32'h0001fffe);
    wb(1'b1, CORE_CTL_OFS, 32'h0, rd);
    check(core_control_word, 32'h0500);
    mul_chk(MUL_DSP, 16'hc000, 16'h4000, 32'he0000000);
    // unmapped place: answered, reads zero, write lost
    wb(1'b1, 4'h8, 32'hffff, rd);
    wb(1'b0, 4'h8, 32'h0, rd);
    check(rd, 32'h0);
    evt(6'h30);
    check(cpu_status_word[15:10], 32'h22);
    evt(6'h07);
    check(cpu_status_word[15:10], 32'h37);
    evt(6'h20);
    check(cpu_status_word[15:10], 32'h17);
    evt(6'h24);
    check(cpu_status_word[15:10], 32'h05);
    wb(1'b1, STATUS_OFS, 32'h3400, rd);
    check(cpu_status_word[15:10], 32'h05);
    evt(6'h28);
    check(cpu_status_word[15:10], 32'h0d);
    wb(1'b1, STATUS_OFS, 32'h3000, rd);
    check(cpu_status_word[15:10], 32'h0);
    core_in.do_loop_active <= 1'b1;
    core_in.repeat_loop_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({cpu_status_word[ST_DO_ACT], cpu_status_word[ST_REP_ACT]}, 32'h3);
    core_in.do_loop_active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({cpu_status_word[ST_DO_ACT], cpu_status_word[ST_REP_ACT]}, 32'h1);
    wb(1'b1, STATUS_OFS, 32'h00e0, rd);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check({rd[15:0], user_irq_off}, {16'h00f0, 1'b1});
    wb(1'b1, STATUS_OFS, 32'h00c0, rd);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check(user_irq_off, 32'h0);
    core_in.nesting_disable <= 1'b1;
    wb(1'b1, STATUS_OFS, 32'h00e0, rd);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check(rd, 32'h00d0);
    core_in.prio_load <= 1'b1;
    core_in.prio_value <= 4'h8;
    @(posedge clk_sys);
    core_in.prio_load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({core_control_word[CC_PRIO_MSB], cpu_status_word[7:5], user_irq_off}, 32'h11);
    core_in.nesting_disable <= 1'b0;
    wb(1'b1, CORE_CTL_OFS, 32'h0, rd);
    check(core_control_word[CC_PRIO_MSB], 32'h0);
    alu_chk(OP_ADD, 1'b0, 16'h7fff, 16'h0001, 5'h1f, 16'h8000, 5'h1c);
    alu_chk(OP_SUB, 1'b0, 16'h0005, 16'h0005, 5'h1f, 16'h0000, 5'h13);
    alu_chk(OP_ADDC, 1'b0, 16'h0001, 16'h0001, 5'h1f, 16'h0003, 5'h00);
    alu_chk(OP_SUBB, 1'b0, 16'h0005, 16'h0002, 5'h1f, 16'h0002, 5'h11);
    alu_chk(OP_ADD, 1'b1, 16'h000f, 16'h0001, 5'h1f, 16'h0010, 5'h10);
    alu_chk(OP_ADD, 1'b1, 16'h00ff, 16'h0001, 5'h1f, 16'h0000, 5'h13);
    alu_chk(OP_AND, 1'b0, 16'hf0f0, 16'h0f0f, 5'h0a, 16'h0000, 5'h13);
    alu_chk(OP_XOR, 1'b0, 16'h8000, 16'h0001, 5'h0a, 16'h8001, 5'h19);
    alu_chk(OP_IOR, 1'b0, 16'h0000, 16'h0000, 5'h0a, 16'h0000, 5'h13);
    alu_chk(OP_SUB, 1'b0, 16'h0000, 16'h0001, 5'h1f, 16'hffff, 5'h08);
    alu_chk(OP_SLL, 1'b0, 16'h4001, 16'h0000, 5'h0a, 16'h8002, 5'h08);
    alu_chk(OP_LSR, 1'b0, 16'h8000, 16'h0000, 5'h0a, 16'h4000, 5'h00);
    alu_chk(OP_ASR, 1'b0, 16'h8000, 16'h0000, 5'h0a, 16'hc000, 5'h08);
    alu_chk(OP_ADD, 1'b0, 16'h0001, 16'h0001, 5'h00, 16'h0002, 5'h08);
    mul_chk(MUL_SS, 16'hffff, 16'h0002, 32'hfffffffe);
    mul_chk(MUL_UU, 16'hffff, 16'h0002, 32'h0001fffe);
    mul_chk(MUL_SU, 16'h8000, 16'h0002, 32'hffff0000);
    mul_chk(MUL_US, 16'h8000, 16'hffff, 32'hffff8000);
    mul_chk(MUL_SLIT, 16'hffff, 16'h001f, 32'hffffffe1);
    mul_chk(MUL_ULIT, 16'hffff, 16'hffff, 32'h001effe1);
    mul_chk(MUL_UU8, 16'h12ff, 16'h34ff, 32'h0000fe01);
    div_chk(1'b0, 1'b1, 1'b0, 32'h00010000, 16'h0003, 32'h55550001);
    div_chk(1'b1, 1'b1, 1'b1, 32'hfffe7960, 16'h03e8, 32'hff9c0000);
    div_chk(1'b1, 1'b0, 1'b0, 32'h0000ff9c, 16'h0007, 32'hfff2fffe);
    stop_test;
  end
endmodule
